// ==== hdl/watchdog_unit_pkg.sv ====
// Constants, register map and state types of the windowed watchdog
package watchdog_unit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the plain register port
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_CNT_HI = 3'h2;
  localparam logic [2:0] ADDR_CNT_LO = 3'h3;
  localparam logic [2:0] ADDR_TOV_HI = 3'h4;
  localparam logic [2:0] ADDR_TOV_LO = 3'h5;
  localparam logic [2:0] ADDR_WIN_HI = 3'h6;
  localparam logic [2:0] ADDR_WIN_LO = 3'h7;

  // Write-once tracking slots, one per configuration byte
  localparam int SLOT_CTRL1 = 0;
  localparam int SLOT_CTRL2 = 1;
  localparam int SLOT_TOV_HI = 2;
  localparam int SLOT_TOV_LO = 3;
  localparam int SLOT_WIN_HI = 4;
  localparam int SLOT_WIN_LO = 5;
  localparam int SLOT_COUNT = 6;

  // control_status_one fields
  localparam int C1_ENABLE = 7;
  localparam int C1_INT_EN = 6;
  localparam int C1_UPDATE = 5;
  localparam int C1_DEBUG_RUN = 2;
  localparam int C1_WAIT_RUN = 1;
  localparam int C1_STOP_RUN = 0;
  localparam logic [7:0] C1_WRITE_MASK = 8'hE7;

  // control_status_two fields
  localparam int C2_WINDOW = 7;
  localparam int C2_FLAG = 6;
  localparam int C2_PRESCALE = 4;
  localparam int C2_CLK_LSB = 0;
  localparam logic [7:0] C2_WRITE_MASK = 8'h93;

  // Clock select codes
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_LPO = 2'h1;
  localparam logic [1:0] CLK_IRC32K = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;

  // Reset values
  localparam int LPO_HZ = 1000;
  localparam int DEFAULT_TIMEOUT_MS = 4;
  localparam logic [15:0] TOV_RESET = 16'(DEFAULT_TIMEOUT_MS * LPO_HZ / 1000);
  localparam logic [7:0] CTRL1_RESET = 8'h80;
  localparam logic [7:0] CTRL2_RESET = 8'h01;
  localparam logic [15:0] WIN_RESET = 16'h0000;

  // Sequence words written to the counter pair
  localparam logic [15:0] REFRESH_WORD1 = 16'hA602;
  localparam logic [15:0] REFRESH_WORD2 = 16'hB480;
  localparam logic [15:0] UNLOCK_WORD1 = 16'hC520;
  localparam logic [15:0] UNLOCK_WORD2 = 16'hD928;

  // Timing, in bus clocks; prescale and hold counts in counter source ticks
  localparam logic [7:0] CFG_WINDOW_CYCLES = 8'h80;
  localparam logic [4:0] SEQ_GAP_CYCLES = 5'h10;
  localparam logic [7:0] RESET_DELAY_CYCLES = 8'h80;
  localparam logic [7:0] PRESCALE_LAST = 8'hFF;
  // Hold of 2.5 source periods rounded up to whole edges
  localparam logic [1:0] HOLD_EDGES = 2'h3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REFRESH, SEQ_UNLOCK} seq_t;
  typedef enum logic [1:0] {HOLD_NONE, HOLD_OLD, HOLD_NEW} hold_t;

endpackage : watchdog_unit_pkg

// ==== hdl/windowed_watchdog_timer.sv ====
// Windowed watchdog_unit: counter, refresh/unlock sequences, config, reset
// What this block does
// - Refresh A602 then B480 within 16
// - Early refresh in window mode forces reset
// - Config registers write-once until reset/unlock
// - New config applies once all written
// - Window pair optional when window disabled
// - Unlock honoured only if update bit set
// - Unlock C520 then D928 within 16
// - Reconfigure within 128 after unlock, else reset
// - Four counter clock sources, LOW_POWER_OSC_1KHZ default
// - Optional divide-by-256 for every source
// - Default timeout about 4 ms on LOW_POWER_OSC_1KHZ
// - Clock change holds counter for 2.5+2.5 periods
// - Interrupt first, reset 128 clocks later
// - Interrupt disabled: reset immediately
// - Two overflows reset on non-bus clock
// - Stops in debug/wait/stop3 unless enabled
// - No interrupt or wake in stop3
// - Debug/stop3 run needs non-bus clock
// - Valid refresh clears counter to zero
// - Any other counter write forces reset
// - Reset when counter reaches timeout value
// - Clock select codes 00 bus..11 external
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps

module windowed_watchdog_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Counter clock sources from pins, asynchronous
  input wire logic lowPowerOsc1khz,
  input wire logic irc32kClk,
  input wire logic extClk,
  // Chip mode, same clock domain
  input wire logic backgroundDebug,
  input wire logic waitMode,
  input wire logic stop3Mode,
  // Results
  output logic watchdogIrq,
  output logic watchdogReset
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0][2:0] srcPipe;
    logic [7:0] pre;
    logic [15:0] cnt;
    logic [7:0] ctrl1Sh;
    logic [7:0] ctrl2Sh;
    logic [15:0] tovSh;
    logic [15:0] winSh;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] tov;
    logic [15:0] early_refresh_check_enable;
    logic [5:0] written;
    logic cfgOpen;
    logic reopened;
    logic [7:0] cfgTimer;
    logic [7:0] hiLatch;
    logic hiPending;
    watchdog_unit_pkg::seq_t seq;
    logic [4:0] seqTimer;
    watchdog_unit_pkg::hold_t hold;
    logic [1:0] holdCnt;
    logic [1:0] oldClk;
    logic ovfSeen;
    logic flag;
    logic irq;
    logic pendRst;
    logic [7:0] rstTimer;
    logic sysReset;
    logic [7:0] rdData;
  } state_t;

  state_t s;
  state_t next_s;

  logic [2:0] srcEdge;
  logic [2:0] srcPins;

  assign srcPins = {extClk, irc32kClk, lowPowerOsc1khz};

  // Tick of a selected source: bus clock ticks every cycle
  function automatic logic srcTick(input logic [1:0] sel, input logic [2:0] edges);
    logic t;
    t = 1'b1;
    if (sel != watchdog_unit_pkg::CLK_BUS) begin
      t = edges[sel - 2'h1];
    end
    return t;
  endfunction : srcTick

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic running;
    logic tick;
    logic counted;
    logic trig;
    logic backup;
    logic word;
    logic [15:0] wordVal;
    logic winReady;
    logic done;
    logic [1:0] clkSel;
    next_s = s;
    running = 1'b0;
    tick = 1'b0;
    counted = 1'b0;
    trig = 1'b0;
    backup = 1'b0;
    word = 1'b0;
    wordVal = 16'h0000;
    winReady = 1'b0;
    done = 1'b0;
    clkSel = s.ctrl2[watchdog_unit_pkg::C2_CLK_LSB +: 2];

    // Pin clocks: two flops, then an edge detect on the later stages
    for (int i = 0; i < 3; i++) begin
      next_s.srcPipe[i] = {s.srcPipe[i][1:0], srcPins[i]};
      srcEdge[i] = s.srcPipe[i][1] & ~s.srcPipe[i][2];
    end

    // Mode gating; debug and stop3 need a non-bus source
    running = s.ctrl1[watchdog_unit_pkg::C1_ENABLE];
    if (backgroundDebug && !(s.ctrl1[watchdog_unit_pkg::C1_DEBUG_RUN] && clkSel != watchdog_unit_pkg::CLK_BUS)) begin
      running = 1'b0;
    end
    if (waitMode && !s.ctrl1[watchdog_unit_pkg::C1_WAIT_RUN]) begin
      running = 1'b0;
    end
    if (stop3Mode && !(s.ctrl1[watchdog_unit_pkg::C1_STOP_RUN] && clkSel != watchdog_unit_pkg::CLK_BUS)) begin
      running = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock-change hold, then counting
    case (s.hold)
      watchdog_unit_pkg::HOLD_OLD: begin
        next_s.cnt = 16'h0000;
        if (srcTick(s.oldClk, srcEdge)) begin
          next_s.holdCnt = s.holdCnt + 2'h1;
          if (s.holdCnt == watchdog_unit_pkg::HOLD_EDGES - 2'h1) begin
            next_s.hold = watchdog_unit_pkg::HOLD_NEW;
            next_s.holdCnt = 2'h0;
          end
        end
      end
      watchdog_unit_pkg::HOLD_NEW: begin
        next_s.cnt = 16'h0000;
        if (srcTick(clkSel, srcEdge)) begin
          next_s.holdCnt = s.holdCnt + 2'h1;
          if (s.holdCnt == watchdog_unit_pkg::HOLD_EDGES - 2'h1) begin
            next_s.hold = watchdog_unit_pkg::HOLD_NONE;
            next_s.holdCnt = 2'h0;
          end
        end
      end
      default: begin
        tick = running && srcTick(clkSel, srcEdge);
        if (tick && s.ctrl2[watchdog_unit_pkg::C2_PRESCALE]) begin
          next_s.pre = s.pre + 8'h01;
          counted = (s.pre == watchdog_unit_pkg::PRESCALE_LAST);
        end else begin
          counted = tick;
        end
        if (counted) begin
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt == 16'hFFFF && clkSel != watchdog_unit_pkg::CLK_BUS) begin
            next_s.ovfSeen = 1'b1;
            backup = s.ovfSeen;
          end
        end
      end
    endcase

    // Timeout compare
    if (running && s.cnt == s.tov) begin
      trig = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter pair writes: high byte latched, low byte completes a word
    if (regWr && regAddr == watchdog_unit_pkg::ADDR_CNT_HI) begin
      next_s.hiLatch = regWrData;
      next_s.hiPending = 1'b1;
    end
    if (regWr && regAddr == watchdog_unit_pkg::ADDR_CNT_LO) begin
      next_s.hiPending = 1'b0;
      if (s.hiPending) begin
        word = 1'b1;
        wordVal = {s.hiLatch, regWrData};
      end else begin
        trig = 1'b1;
      end
    end

    case (s.seq)
      watchdog_unit_pkg::SEQ_REFRESH, watchdog_unit_pkg::SEQ_UNLOCK: begin
        if (word) begin
          next_s.seq = watchdog_unit_pkg::SEQ_IDLE;
          if (s.seq == watchdog_unit_pkg::SEQ_REFRESH && wordVal == watchdog_unit_pkg::REFRESH_WORD2) begin
            next_s.cnt = 16'h0000;
            next_s.pre = 8'h00;
            next_s.ovfSeen = 1'b0;
          end else if (s.seq == watchdog_unit_pkg::SEQ_UNLOCK && wordVal == watchdog_unit_pkg::UNLOCK_WORD2) begin
            next_s.cfgOpen = 1'b1;
            next_s.reopened = 1'b1;
            next_s.cfgTimer = 8'h00;
            next_s.written = '0;
          end else begin
            trig = 1'b1;
          end
        end else if (s.seqTimer == watchdog_unit_pkg::SEQ_GAP_CYCLES) begin
          next_s.seq = watchdog_unit_pkg::SEQ_IDLE;
          trig = 1'b1;
        end else begin
          next_s.seqTimer = s.seqTimer + 5'h01;
        end
      end
      default: begin
        if (word) begin
          next_s.seqTimer = 5'h01;
          if (wordVal == watchdog_unit_pkg::REFRESH_WORD1) begin
            // Early start counts as a failed refresh
            if (s.ctrl2[watchdog_unit_pkg::C2_WINDOW] && s.cnt < s.early_refresh_check_enable) begin
              trig = 1'b1;
            end else begin
              next_s.seq = watchdog_unit_pkg::SEQ_REFRESH;
            end
          end else if (wordVal == watchdog_unit_pkg::UNLOCK_WORD1 && !s.cfgOpen
                       && s.ctrl1[watchdog_unit_pkg::C1_UPDATE]) begin
            next_s.seq = watchdog_unit_pkg::SEQ_UNLOCK;
          end else begin
            trig = 1'b1;
          end
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Write-once configuration shadows
    if (regWr && s.cfgOpen) begin
      case (regAddr)
        watchdog_unit_pkg::ADDR_CTRL1: begin
          if (!s.written[watchdog_unit_pkg::SLOT_CTRL1]) begin
            next_s.ctrl1Sh = regWrData & watchdog_unit_pkg::C1_WRITE_MASK;
            next_s.written[watchdog_unit_pkg::SLOT_CTRL1] = 1'b1;
          end
        end
        watchdog_unit_pkg::ADDR_CTRL2: begin
          if (!s.written[watchdog_unit_pkg::SLOT_CTRL2]) begin
            next_s.ctrl2Sh = regWrData & watchdog_unit_pkg::C2_WRITE_MASK;
            next_s.written[watchdog_unit_pkg::SLOT_CTRL2] = 1'b1;
          end
        end
        watchdog_unit_pkg::ADDR_TOV_HI: begin
          if (!s.written[watchdog_unit_pkg::SLOT_TOV_HI]) begin
            next_s.tovSh[15:8] = regWrData;
            next_s.written[watchdog_unit_pkg::SLOT_TOV_HI] = 1'b1;
          end
        end
        watchdog_unit_pkg::ADDR_TOV_LO: begin
          if (!s.written[watchdog_unit_pkg::SLOT_TOV_LO]) begin
            next_s.tovSh[7:0] = regWrData;
            next_s.written[watchdog_unit_pkg::SLOT_TOV_LO] = 1'b1;
          end
        end
        watchdog_unit_pkg::ADDR_WIN_HI: begin
          if (!s.written[watchdog_unit_pkg::SLOT_WIN_HI]) begin
            next_s.winSh[15:8] = regWrData;
            next_s.written[watchdog_unit_pkg::SLOT_WIN_HI] = 1'b1;
          end
        end
        watchdog_unit_pkg::ADDR_WIN_LO: begin
          if (!s.written[watchdog_unit_pkg::SLOT_WIN_LO]) begin
            next_s.winSh[7:0] = regWrData;
            next_s.written[watchdog_unit_pkg::SLOT_WIN_LO] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Flag clears by writing one, at any time; a new set below still wins
    if (regWr && regAddr == watchdog_unit_pkg::ADDR_CTRL2 && regWrData[watchdog_unit_pkg::C2_FLAG]) begin
      next_s.flag = 1'b0;
    end

    // Apply once every needed byte is in; window pair only if window on
    winReady = !next_s.ctrl2Sh[watchdog_unit_pkg::C2_WINDOW]
               || (next_s.written[watchdog_unit_pkg::SLOT_WIN_HI] && next_s.written[watchdog_unit_pkg::SLOT_WIN_LO]);
    done = (&next_s.written[watchdog_unit_pkg::SLOT_TOV_LO:watchdog_unit_pkg::SLOT_CTRL1]) && winReady;
    if (s.cfgOpen) begin
      if (done) begin
        next_s.cfgOpen = 1'b0;
        next_s.reopened = 1'b0;
        next_s.ctrl1 = next_s.ctrl1Sh;
        next_s.ctrl2 = next_s.ctrl2Sh;
        next_s.tov = next_s.tovSh;
        next_s.early_refresh_check_enable = next_s.winSh;
        next_s.cnt = 16'h0000;
        next_s.pre = 8'h00;
        next_s.ovfSeen = 1'b0;
        if (next_s.ctrl2Sh[watchdog_unit_pkg::C2_CLK_LSB +: 2] != clkSel) begin
          next_s.hold = watchdog_unit_pkg::HOLD_OLD;
          next_s.holdCnt = 2'h0;
          next_s.oldClk = clkSel;
        end
      end else if (s.cfgTimer == watchdog_unit_pkg::CFG_WINDOW_CYCLES - 8'h01) begin
        // First window lapses quietly on defaults; a reopened one does not
        next_s.cfgOpen = 1'b0;
        next_s.reopened = 1'b0;
        trig = trig || s.reopened;
      end else begin
        next_s.cfgTimer = s.cfgTimer + 8'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset generation
    if (backup) begin
      next_s.sysReset = 1'b1;
    end
    if (trig && !s.pendRst && !s.sysReset) begin
      if (s.ctrl1[watchdog_unit_pkg::C1_INT_EN] && !stop3Mode) begin
        next_s.flag = 1'b1;
        next_s.pendRst = 1'b1;
        next_s.rstTimer = 8'h00;
      end else begin
        // Stop3 cannot take an interrupt, so no delay there either
        next_s.sysReset = 1'b1;
      end
    end
    if (s.pendRst) begin
      next_s.rstTimer = s.rstTimer + 8'h01;
      if (s.rstTimer == watchdog_unit_pkg::RESET_DELAY_CYCLES - 8'h01) begin
        next_s.sysReset = 1'b1;
      end
    end
    next_s.irq = next_s.flag && s.ctrl1[watchdog_unit_pkg::C1_INT_EN] && !stop3Mode;

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe
    next_s.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        watchdog_unit_pkg::ADDR_CTRL1: next_s.rdData = s.ctrl1Sh;
        watchdog_unit_pkg::ADDR_CTRL2: next_s.rdData = s.ctrl2Sh | {1'b0, s.flag, 6'h00};
        watchdog_unit_pkg::ADDR_CNT_HI: next_s.rdData = s.cnt[15:8];
        watchdog_unit_pkg::ADDR_CNT_LO: next_s.rdData = s.cnt[7:0];
        watchdog_unit_pkg::ADDR_TOV_HI: next_s.rdData = s.tovSh[15:8];
        watchdog_unit_pkg::ADDR_TOV_LO: next_s.rdData = s.tovSh[7:0];
        watchdog_unit_pkg::ADDR_WIN_HI: next_s.rdData = s.winSh[15:8];
        default: next_s.rdData = s.winSh[7:0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s <= '0;
      s.ctrl1Sh <= watchdog_unit_pkg::CTRL1_RESET;
      s.ctrl2Sh <= watchdog_unit_pkg::CTRL2_RESET;
      s.tovSh <= watchdog_unit_pkg::TOV_RESET;
      s.winSh <= watchdog_unit_pkg::WIN_RESET;
      s.ctrl1 <= watchdog_unit_pkg::CTRL1_RESET;
      s.ctrl2 <= watchdog_unit_pkg::CTRL2_RESET;
      s.tov <= watchdog_unit_pkg::TOV_RESET;
      s.early_refresh_check_enable <= watchdog_unit_pkg::WIN_RESET;
      s.cfgOpen <= 1'b1;
      s.seq <= watchdog_unit_pkg::SEQ_IDLE;
      s.hold <= watchdog_unit_pkg::HOLD_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData = s.rdData;
  assign watchdogIrq = s.irq;
  assign watchdogReset = s.sysReset;

endmodule : windowed_watchdog_timer

// ==== sim/tb_windowed_watchdog_timer.sv ====
// Self-checking bench for the windowed watchdog
`timescale 1ns/100ps

module tb_windowed_watchdog_timer;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic lowPowerOsc1khz = 1'b0;
  logic irc32kClk = 1'b0;
  logic extClk = 1'b0;
  logic backgroundDebug = 1'b0;
  logic waitMode = 1'b0;
  logic stop3Mode = 1'b0;
  logic watchdogIrq;
  logic watchdogReset;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] a;
  logic [7:0] b;
  int n;
  int m;

  always #5 core_clk = ~core_clk;
  // Sources scaled far up to keep runs short; all stay below a third of core_clk
  always #100 lowPowerOsc1khz = ~lowPowerOsc1khz;
  always #70 irc32kClk = ~irc32kClk;
  always #30 extClk = ~extClk;

  windowed_watchdog_timer u_windowed_watchdog_timer (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .lowPowerOsc1khz(lowPowerOsc1khz), .irc32kClk(irc32kClk), .extClk(extClk),
    .backgroundDebug(backgroundDebug), .waitMode(waitMode), .stop3Mode(stop3Mode),
    .watchdogIrq(watchdogIrq), .watchdogReset(watchdogReset)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] inRange(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction : inRange

  task automatic wr(input logic [2:0] adr, input logic [7:0] dat);
    @(posedge core_clk);
    regAddr <= adr;
    regWrData <= dat;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] adr, output logic [7:0] dat);
    @(posedge core_clk);
    regAddr <= adr;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 dat = regRdData;
  endtask : rd

  task automatic wordWr(input logic [15:0] w);
    wr(watchdog_unit_pkg::ADDR_CNT_HI, w[15:8]);
    wr(watchdog_unit_pkg::ADDR_CNT_LO, w[7:0]);
  endtask : wordWr

  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] tov,
    input logic [15:0] early_refresh_check_enable);
    wr(watchdog_unit_pkg::ADDR_TOV_HI, tov[15:8]);
    wr(watchdog_unit_pkg::ADDR_TOV_LO, tov[7:0]);
    if (c2[7]) begin
      wr(watchdog_unit_pkg::ADDR_WIN_HI, early_refresh_check_enable[15:8]);
      wr(watchdog_unit_pkg::ADDR_WIN_LO, early_refresh_check_enable[7:0]);
    end
    wr(watchdog_unit_pkg::ADDR_CTRL2, c2);
    wr(watchdog_unit_pkg::ADDR_CTRL1, c1);
  endtask : cfg

  task automatic doReset;
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
  endtask : doReset

  // Counts cycles until reset (or interrupt); a required event that never comes ends the run
  task automatic waitEv(input int limit, input bit anyEv, input bit must, output int cnt);
    cnt = 0;
    while (!(watchdogReset === 1'b1 || (anyEv && watchdogIrq === 1'b1)) && cnt < limit) begin
      @(posedge core_clk);
      #1 cnt++;
    end
    if (must && cnt >= limit) begin
      fail_count++;
      end_sim();
    end
  endtask : waitEv

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    doReset();
    rd(watchdog_unit_pkg::ADDR_CTRL1, a);
    check({8'h00, a}, 16'h0080);
    rd(watchdog_unit_pkg::ADDR_CTRL2, a);
    check({14'h0, a[1:0]}, 16'h0001);
    rd(watchdog_unit_pkg::ADDR_TOV_LO, a);
    check({8'h00, a}, 16'h0004);
    waitEv(400, 1, 1, n);
    check(inRange(n, 40, 100), 16'h0001);
    check(16'(watchdogIrq), 16'h0000);
    $display("test defaults done");

    doReset();
    cfg(8'h80, 8'h00, 16'h0080, 16'h0000);
    // Source change to bus clock: counter parked at zero for several slow edges
    rd(watchdog_unit_pkg::ADDR_CNT_LO, a);
    check({8'h00, a}, 16'h0000);
    repeat (80) @(posedge core_clk);
    wr(watchdog_unit_pkg::ADDR_TOV_LO, 8'h10);
    rd(watchdog_unit_pkg::ADDR_TOV_LO, a);
    check({8'h00, a}, 16'h0080);
    wordWr(watchdog_unit_pkg::REFRESH_WORD1);
    wordWr(watchdog_unit_pkg::REFRESH_WORD2);
    rd(watchdog_unit_pkg::ADDR_CNT_LO, a);
    rd(watchdog_unit_pkg::ADDR_CNT_LO, b);
    check(16'(a < 8'h08), 16'h0001);
    check({8'h00, b - a}, 16'h0002);
    waitEv(300, 0, 1, n);
    check(inRange(n, 115, 130), 16'h0001);
    $display("test refresh done");

    for (int ie = 0; ie < 2; ie++) begin
      for (int k = 0; k < 3; k++) begin
        doReset();
        cfg(ie ? 8'hC0 : 8'h80, 8'h00, 16'h1000, 16'h0000);
        repeat (150) @(posedge core_clk);
        wordWr(k == 0 ? watchdog_unit_pkg::REFRESH_WORD1 : k == 1 ? 16'h1234 : watchdog_unit_pkg::UNLOCK_WORD1);
        waitEv(40, 1, 1, n);
        check(inRange(n, k ? 0 : 15, k ? 3 : 19), 16'h0001);
        check({14'h0, watchdogIrq, watchdogReset}, ie ? 16'h0002 : 16'h0001);
        if (ie) begin
          rd(watchdog_unit_pkg::ADDR_CTRL2, a);
          check({15'h0, a[6]}, 16'h0001);
          waitEv(200, 0, 1, m);
          check(inRange(m, 122, 128), 16'h0001);
        end
      end
    end
    // Stop3 with interrupt enabled: no interrupt, reset at once
    doReset();
    cfg(8'hC1, 8'h01, 16'h1000, 16'h0000);
    repeat (20) @(posedge core_clk);
    stop3Mode <= 1'b1;
    wordWr(16'h1234);
    waitEv(40, 1, 1, n);
    check({14'h0, watchdogIrq, watchdogReset}, 16'h0001);
    check(inRange(n, 0, 3), 16'h0001);
    stop3Mode <= 1'b0;
    $display("test faults done");

    for (int w = 0; w < 2; w++) begin
      doReset();
      cfg(8'h80, 8'h80, 16'h1000, 16'h0100);
      repeat (w ? 400 : 150) @(posedge core_clk);
      wordWr(watchdog_unit_pkg::REFRESH_WORD1);
      wordWr(watchdog_unit_pkg::REFRESH_WORD2);
      waitEv(50, 1, 0, n);
      check(inRange(n, 0, 49), w ? 16'h0000 : 16'h0001);
    end
    $display("test window done");

    for (int r = 0; r < 2; r++) begin
      doReset();
      cfg(8'hA0, 8'h00, 16'h1000, 16'h0000);
      repeat (150) @(posedge core_clk);
      wordWr(watchdog_unit_pkg::UNLOCK_WORD1);
      wordWr(watchdog_unit_pkg::UNLOCK_WORD2);
      if (r) begin
        cfg(8'h80, 8'h00, 16'h0030, 16'h0000);
      end
      waitEv(300, 1, 1, n);
      check(inRange(n, r ? 40 : 118, r ? 52 : 132), 16'h0001);
    end
    $display("test unlock done");

    for (int md = 0; md < 3; md++) begin
      doReset();
      cfg(8'h84, 8'h00, 16'h1000, 16'h0000);
      repeat (100) @(posedge core_clk);
      backgroundDebug <= (md == 0);
      waitMode <= (md == 1);
      stop3Mode <= (md == 2);
      rd(watchdog_unit_pkg::ADDR_CNT_LO, a);
      repeat (10) @(posedge core_clk);
      rd(watchdog_unit_pkg::ADDR_CNT_LO, b);
      check({8'h00, b}, {8'h00, a});
      backgroundDebug <= 1'b0;
      waitMode <= 1'b0;
      stop3Mode <= 1'b0;
    end
    $display("test modes done");

    doReset();
    cfg(8'h80, 8'h10, 16'h0002, 16'h0000);
    waitEv(1500, 1, 1, n);
    check(inRange(n, 480, 720), 16'h0001);
    $display("test prescale done");
    end_sim();
  end
endmodule : tb_windowed_watchdog_timer

// ==== sim/windowed_watchdog_timer_monitor.sv ====
// Port-level assertions for the windowed watchdog
`timescale 1ns/100ps

module windowed_watchdog_timer_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Mode and results
  input wire logic stop3Mode,
  input wire logic watchdogIrq,
  input wire logic watchdogReset
);
  logic [7:0] hiByte;
  logic [4:0] gapCnt;
  logic [15:0] word;
  logic lowWr;
  logic firstWord;
  logic badWord;
  logic hit;

  always_comb begin
    word = {hiByte, regWrData};
    lowWr = regWr && regAddr == watchdog_unit_pkg::ADDR_CNT_LO;
    firstWord = lowWr && (word == watchdog_unit_pkg::REFRESH_WORD1 || word == watchdog_unit_pkg::UNLOCK_WORD1);
    badWord = lowWr && !(word inside {watchdog_unit_pkg::REFRESH_WORD1, watchdog_unit_pkg::REFRESH_WORD2,
      watchdog_unit_pkg::UNLOCK_WORD1, watchdog_unit_pkg::UNLOCK_WORD2});
    hit = watchdogReset || watchdogIrq;
  end

  // Gap counter saturates so a stale sequence cannot wrap back to 17
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hiByte <= 8'h00;
      gapCnt <= 5'h00;
    end else begin
      if (regWr && regAddr == watchdog_unit_pkg::ADDR_CNT_HI) begin
        hiByte <= regWrData;
      end
      if (lowWr) begin
        gapCnt <= firstWord ? 5'h01 : 5'h00;
      end else if (gapCnt != 5'h00 && gapCnt != 5'h1F) begin
        gapCnt <= gapCnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_rd_idle_zero: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_reset_stays_high: assert property (watchdogReset |=> watchdogReset)
    else $error("reset output dropped without srst");
  a_bad_word_trips: assert property (badWord |-> ##[1:3] hit)
    else $error("illegal counter word did not trip");
  a_seq_gap_trips: assert property (gapCnt == 5'h11 |-> ##[1:3] hit)
    else $error("late second word did not trip");
  a_irq_before_reset: assert property ($rose(watchdogIrq) |-> !watchdogReset [*8])
    else $error("reset came with the interrupt");
  a_reset_after_irq: assert property ($rose(watchdogIrq) |-> ##[127:128] watchdogReset)
    else $error("reset not 128 cycles after interrupt");
  a_irq_flag_sticky: assert property (watchdogIrq && !regWr && !stop3Mode |=> watchdogIrq)
    else $error("interrupt dropped without a clear");
  a_stop3_no_irq: assert property ($past(stop3Mode) |-> !watchdogIrq)
    else $error("interrupt raised in stop3");
endmodule : windowed_watchdog_timer_monitor

bind windowed_watchdog_timer windowed_watchdog_timer_monitor u_windowed_watchdog_timer_monitor (
  .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .stop3Mode(stop3Mode),
  .watchdogIrq(watchdogIrq), .watchdogReset(watchdogReset)
);
